/* File: pemux_board.sv */
// Board logic on the connector: drives every pin that the mux leaves undriven.
// Assumes the bench sets the level each undriven pin should carry.
module pemux_board (
    input wire logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] pin_out,
    input wire logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] pin_oe,
    input wire logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] board_lvl,
    output logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import pemux_pkg::*;
    // The board backs off wherever the mux drives, so a pin never sees a fight
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_lvl);
endmodule // pemux_board

/* File: pemux_chk.sv */
// Port checks for the pin multiplexer: output drive, strobes and serial clock.
// Assumes one pclk domain; shadows the select and direction registers from APB writes.
module pemux_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [pemux_pkg::ADDR_W-1:0] paddr,
    input wire logic [pemux_pkg::DATA_W-1:0] pwdata,
    input wire logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] pin_out,
    input wire logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] pin_oe,
    input wire logic timer3_cmp_out_a,
    input wire logic timer3_cmp_out_b,
    input wire logic timer3_cmp_out_c,
    input wire logic serial0_sync_mode,
    input wire logic serial0_clk_drive,
    input wire logic serial0_ext_clk,
    input wire logic ext_irq_7,
    input wire logic timer3_capture_in,
    input wire logic timer3_count_src
);
    timeunit 1ns;
    timeprecision 1ns;
    import pemux_pkg::*;
    logic [ALT_W-1:0] alt_ff;
    logic [PIN_HI:PIN_LO] dir_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow copies change at the same edge as the design's registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_ff <= RST_ALT;
            dir_ff <= RST_PINS;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == OFS_ALT_SEL) alt_ff <= pwdata[ALT_W-1:0];
            if (paddr == OFS_DIR) dir_ff <= pwdata[PIN_HI:PIN_LO];
        end
    end
    // A strobe is high for exactly one cycle
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    property p_oe; pin_oe == $past(dir_ff); endproperty
    property p_cmp_a; alt_ff[ALT_CMP_A] && dir_ff[3] |=> pin_out[3] == $past(timer3_cmp_out_a); endproperty
    property p_cmp_b; alt_ff[ALT_CMP_B] && dir_ff[4] |=> pin_out[4] == $past(timer3_cmp_out_b); endproperty
    property p_cmp_c; alt_ff[ALT_CMP_C] && dir_ff[5] |=> pin_out[5] == $past(timer3_cmp_out_c); endproperty
    property p_ser; alt_ff[ALT_SERIAL] && dir_ff[2] && serial0_sync_mode |=> pin_out[2] == $past(serial0_clk_drive);
    endproperty
    property p_ser_mode;
        serial0_ext_clk |-> $past(serial0_sync_mode) && $past(alt_ff[ALT_SERIAL]) && !$past(dir_ff[2]);
    endproperty
    property p_cap; timer3_capture_in |-> $past(alt_ff[ALT_CAPTURE]) ##0 s_pulse(timer3_capture_in); endproperty
    property p_cnt; timer3_count_src |-> $past(alt_ff[ALT_COUNT]) ##0 s_pulse(timer3_count_src); endproperty
    property p_irq7; ext_irq_7 |-> $past(alt_ff[ALT_IRQ7]); endproperty
    a_oe: assert property (p_oe) else $error("pin enable differs from direction");
    a_cmp_a: assert property (p_cmp_a) else $error("compare A not on pin 3");
    a_cmp_b: assert property (p_cmp_b) else $error("compare B not on pin 4");
    a_cmp_c: assert property (p_cmp_c) else $error("compare C not on pin 5");
    a_ser: assert property (p_ser) else $error("serial clock not driven on pin 2");
    a_ser_mode: assert property (p_ser_mode) else $error("serial clock input outside sync mode");
    a_cap: assert property (p_cap) else $error("bad capture strobe");
    a_cnt: assert property (p_cnt) else $error("bad count strobe");
    a_irq7: assert property (p_irq7) else $error("interrupt 7 while disabled");
endmodule // pemux_chk

bind port_e_alt_function_mux pemux_chk pemux_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .pin_out(pin_out),
    .pin_oe(pin_oe), .timer3_cmp_out_a(timer3_cmp_out_a), .timer3_cmp_out_b(timer3_cmp_out_b),
    .timer3_cmp_out_c(timer3_cmp_out_c), .serial0_sync_mode(serial0_sync_mode),
    .serial0_clk_drive(serial0_clk_drive), .serial0_ext_clk(serial0_ext_clk), .ext_irq_7(ext_irq_7),
    .timer3_capture_in(timer3_capture_in), .timer3_count_src(timer3_count_src));

/* File: pemux_pkg.sv */
// Constants shared by the port pin multiplexer and its register slave.
// Assumes a 32-bit APB with byte addresses and one aligned word per register.
package pemux_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIN_LO = 2;
    localparam int PIN_HI = 7;
    localparam int NPINS = 6;
    localparam int TIMER_W = 16;

    localparam logic [ADDR_W-1:0] OFS_OUT_LATCH = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DIR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PIN_IN = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ALT_SEL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_SENSE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CAPTURE = 8'h1c;

    // Alternate function select fields
    localparam int ALT_W = 12;
    localparam int ALT_IRQ4 = 0;
    localparam int ALT_IRQ5 = 1;
    localparam int ALT_IRQ6 = 2;
    localparam int ALT_IRQ7 = 3;
    localparam int ALT_CAPTURE = 4;
    localparam int ALT_COUNT = 5;
    localparam int ALT_CMP_A = 6;
    localparam int ALT_CMP_B = 7;
    localparam int ALT_CMP_C = 8;
    localparam int ALT_SERIAL = 9;
    localparam int ALT_CAP_FALL = 10;
    localparam int ALT_CNT_FALL = 11;

    // Status and mask layout
    localparam int ST_W = 5;
    localparam int ST_IRQ4 = 0;
    localparam int ST_CAPTURE = 4;

    localparam int NIRQ = 4;

    localparam logic [NPINS-1:0] RST_PINS = 6'h00;
    localparam logic [ALT_W-1:0] RST_ALT = 12'h000;
    localparam logic [NIRQ-1:0] RST_SENSE = 4'h0;
    localparam logic [ST_W-1:0] RST_ST = 5'h00;
    localparam logic [TIMER_W-1:0] RST_CAP = 16'h0000;
    localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
endpackage

/* File: pin_sync2.sv */
// Two-flop synchroniser for a group of pin levels.
// Assumes its inputs are asynchronous to clk; only the second stage may be read.
module pin_sync2 #(
    parameter int WIDTH = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_ff <= '0;
            sync_out <= '0;
        end else begin
            stage1_ff <= async_in;
            sync_out <= stage1_ff;
        end
    end
endmodule // pin_sync2

/* File: port_e_alt_function_mux.sv */
// Pin multiplexer for port bits 7..2 with an APB register slave.
// Assumes the timer, serial port and interrupt controller share pclk.
module port_e_alt_function_mux
    import pemux_pkg::*;
#(
    parameter int TW = pemux_pkg::TIMER_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pemux_pkg::ADDR_W-1:0] paddr,
    input wire logic [pemux_pkg::DATA_W-1:0] pwdata,
    output logic [pemux_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] pin_in,
    output logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] pin_out,
    output logic [pemux_pkg::PIN_HI:pemux_pkg::PIN_LO] pin_oe,
    input wire logic timer3_cmp_out_a,
    input wire logic timer3_cmp_out_b,
    input wire logic timer3_cmp_out_c,
    input wire logic [TW-1:0] timer3_count,
    input wire logic serial0_sync_mode,
    input wire logic serial0_clk_drive,
    output logic serial0_ext_clk,
    output logic ext_irq_4,
    output logic ext_irq_5,
    output logic ext_irq_6,
    output logic ext_irq_7,
    output logic timer3_capture_in,
    output logic timer3_count_src,
    output logic irq
);
    import pemux_pkg::*;

    logic [PIN_HI:PIN_LO] out_latch_ff;
    logic [PIN_HI:PIN_LO] dir_ff;
    logic [ALT_W-1:0] alt_ff;
    logic [NIRQ-1:0] sense_ff;
    logic [ST_W-1:0] status_ff;
    logic [ST_W-1:0] mask_ff;
    logic [TW-1:0] capture_ff;
    logic [NPINS-1:0] pin_sync;
    logic [PIN_HI:PIN_LO] pin_lvl;
    logic [PIN_HI:PIN_LO] pin_prev_ff;
    logic [PIN_HI:PIN_LO] rise;
    logic [PIN_HI:PIN_LO] fall;
    logic [NIRQ-1:0] irq_req;
    logic [NIRQ-1:0] irq_lvl;
    logic capture_evt;
    logic count_evt;
    logic serial_active;
    logic [PIN_HI:PIN_LO] nxt_pin_out;
    logic [PIN_HI:PIN_LO] nxt_pin_oe;
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;
    logic wr_en;
    logic rd_phase;
    logic [DATA_W-1:0] nxt_prdata;
    logic nxt_pslverr;

    // Pins are asynchronous to pclk
    pin_sync2 #(
        .WIDTH(NPINS)
    ) pin_sync2_inst (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    assign pin_lvl = pin_sync;
    assign rise = pin_lvl & ~pin_prev_ff;
    assign fall = ~pin_lvl & pin_prev_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev_ff <= RST_PINS;
        end else begin
            pin_prev_ff <= pin_lvl;
        end
    end

    // Sense bit 0 is active-low level, 1 is rising edge
    always_comb begin
        for (int i = 0; i < NIRQ; i++) begin
            irq_lvl[i] = sense_ff[i] ? rise[PIN_LO + 2 + i] : ~pin_lvl[PIN_LO + 2 + i];
            irq_req[i] = alt_ff[ALT_IRQ4 + i] & irq_lvl[i];
        end
    end

    assign capture_evt = alt_ff[ALT_CAPTURE] &
        (alt_ff[ALT_CAP_FALL] ? fall[PIN_HI] : rise[PIN_HI]);
    assign count_evt = alt_ff[ALT_COUNT] &
        (alt_ff[ALT_CNT_FALL] ? fall[PIN_HI-1] : rise[PIN_HI-1]);

    assign serial_active = alt_ff[ALT_SERIAL] & serial0_sync_mode;

    // Pin drivers; the compare inputs are already PWM shaped by the timer
    always_comb begin
        nxt_pin_out = out_latch_ff;
        nxt_pin_oe = dir_ff;
        if (alt_ff[ALT_CMP_C] && dir_ff[PIN_LO+3]) begin
            nxt_pin_out[PIN_LO+3] = timer3_cmp_out_c;
        end
        if (alt_ff[ALT_CMP_B] && dir_ff[PIN_LO+2]) begin
            nxt_pin_out[PIN_LO+2] = timer3_cmp_out_b;
        end
        if (alt_ff[ALT_CMP_A] && dir_ff[PIN_LO+1]) begin
            nxt_pin_out[PIN_LO+1] = timer3_cmp_out_a;
        end
        if (serial_active && dir_ff[PIN_LO]) begin
            nxt_pin_out[PIN_LO] = serial0_clk_drive;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= RST_PINS;
            pin_oe <= RST_PINS;
        end else begin
            pin_out <= nxt_pin_out;
            pin_oe <= nxt_pin_oe;
        end
    end

    // Serial clock input reads zero when the function is off or driven out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial0_ext_clk <= 1'b0;
        end else begin
            serial0_ext_clk <= serial_active & ~dir_ff[PIN_LO] & pin_lvl[PIN_LO];
        end
    end

    // Interrupt requests and timer strobes to the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_4 <= 1'b0;
            ext_irq_5 <= 1'b0;
            ext_irq_6 <= 1'b0;
            ext_irq_7 <= 1'b0;
            timer3_capture_in <= 1'b0;
            timer3_count_src <= 1'b0;
        end else begin
            ext_irq_4 <= irq_req[0];
            ext_irq_5 <= irq_req[1];
            ext_irq_6 <= irq_req[2];
            ext_irq_7 <= irq_req[3];
            timer3_capture_in <= capture_evt;
            timer3_count_src <= count_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_ff <= RST_CAP;
        end else if (capture_evt) begin
            capture_ff <= timer3_count;
        end
    end

    // APB: one wait state, pready registered in the first access cycle and high in the second
    assign rd_phase = psel & penable & ~pready;
    assign wr_en = psel & penable & pready & pwrite;

    always_comb begin
        nxt_prdata = RST_DATA;
        nxt_pslverr = 1'b0;
        if (paddr == OFS_OUT_LATCH) begin
            nxt_prdata[NPINS+PIN_LO-1:PIN_LO] = out_latch_ff;
        end else if (paddr == OFS_DIR) begin
            nxt_prdata[NPINS+PIN_LO-1:PIN_LO] = dir_ff;
        end else if (paddr == OFS_PIN_IN) begin
            nxt_prdata[NPINS+PIN_LO-1:PIN_LO] = pin_lvl;
        end else if (paddr == OFS_ALT_SEL) begin
            nxt_prdata[ALT_W-1:0] = alt_ff;
        end else if (paddr == OFS_IRQ_SENSE) begin
            nxt_prdata[NIRQ-1:0] = sense_ff;
        end else if (paddr == OFS_IRQ_STATUS) begin
            nxt_prdata[ST_W-1:0] = status_ff;
        end else if (paddr == OFS_IRQ_MASK) begin
            nxt_prdata[ST_W-1:0] = mask_ff;
        end else if (paddr == OFS_CAPTURE) begin
            nxt_prdata[TW-1:0] = capture_ff;
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= RST_DATA;
            pslverr <= 1'b0;
        end else if (rd_phase) begin
            pready <= 1'b1;
            prdata <= pwrite ? RST_DATA : nxt_prdata;
            pslverr <= nxt_pslverr;
        end else begin
            pready <= 1'b0;
            prdata <= RST_DATA;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_latch_ff <= RST_PINS;
            dir_ff <= RST_PINS;
            alt_ff <= RST_ALT;
            sense_ff <= RST_SENSE;
            mask_ff <= RST_ST;
        end else if (wr_en) begin
            if (paddr == OFS_OUT_LATCH) begin
                out_latch_ff <= pwdata[NPINS+PIN_LO-1:PIN_LO];
            end else if (paddr == OFS_DIR) begin
                dir_ff <= pwdata[NPINS+PIN_LO-1:PIN_LO];
            end else if (paddr == OFS_ALT_SEL) begin
                alt_ff <= pwdata[ALT_W-1:0];
            end else if (paddr == OFS_IRQ_SENSE) begin
                sense_ff <= pwdata[NIRQ-1:0];
            end else if (paddr == OFS_IRQ_MASK) begin
                mask_ff <= pwdata[ST_W-1:0];
            end
        end
    end

    // Sticky status; a new event beats a write-one clear in the same cycle
    assign st_set = {capture_evt, irq_req};
    assign st_clr = (wr_en && paddr == OFS_IRQ_STATUS) ? pwdata[ST_W-1:0] : RST_ST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= RST_ST;
        end else begin
            status_ff <= (status_ff & ~st_clr) | st_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_ff & mask_ff);
        end
    end
endmodule // port_e_alt_function_mux

/* File: tb_port_e_alt_function_mux.sv */
// Self-checking bench for the pin multiplexer, driven over APB.
// Assumes pemux_board on the pins and the bound checker.
module tb_port_e_alt_function_mux;
    timeunit 1ns;
    timeprecision 1ns;
    import pemux_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, serial0_ext_clk;
    logic timer3_cmp_out_a = 0, timer3_cmp_out_b = 0, timer3_cmp_out_c = 0, serial0_sync_mode = 0;
    logic serial0_clk_drive = 0, ext_irq_7, timer3_capture_in, timer3_count_src;
    logic ext_irq_4, ext_irq_5, ext_irq_6;
    logic [15:0] tcount = 16'h1234;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [7:2] pin_in, pin_out, pin_oe, ext = 0;
    logic e;
    int fail_count = 0, total_checks = 0, cnt_src = 0, cap_hi = 0, irq_hi = 0;
    always #5 pclk = ~pclk;
    // Cycles counted per strobe, so a strobe stuck high shows up as too many
    always @(posedge pclk) begin
        if (timer3_count_src === 1'b1) cnt_src++;
        if (timer3_capture_in === 1'b1) cap_hi++;
        irq_hi += $countones({ext_irq_7, ext_irq_6, ext_irq_5, ext_irq_4});
    end
    port_e_alt_function_mux port_e_alt_function_mux_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .timer3_cmp_out_a(timer3_cmp_out_a),
        .timer3_cmp_out_b(timer3_cmp_out_b), .timer3_cmp_out_c(timer3_cmp_out_c), .timer3_count(tcount),
        .serial0_sync_mode(serial0_sync_mode), .serial0_clk_drive(serial0_clk_drive),
        .serial0_ext_clk(serial0_ext_clk), .ext_irq_4(ext_irq_4), .ext_irq_5(ext_irq_5),
        .ext_irq_6(ext_irq_6), .ext_irq_7(ext_irq_7),
        .timer3_capture_in(timer3_capture_in), .timer3_count_src(timer3_count_src), .irq(irq));
    pemux_board pemux_board_inst (.pin_out(pin_out), .pin_oe(pin_oe), .board_lvl(ext), .pin_in(pin_in));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        if (n >= 50) fail_count++;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk("prdata", r, exp);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        summarize;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        rd(OFS_ALT_SEL, 0);
        rd(OFS_DIR, 0);
        wr(OFS_DIR, 32'h3c);
        wr(OFS_OUT_LATCH, 32'h3c);
        wr(OFS_ALT_SEL, 32'h3c0);
        serial0_sync_mode <= 1;
        for (int i = 0; i < 16; i++) begin
            {timer3_cmp_out_c, timer3_cmp_out_b, timer3_cmp_out_a, serial0_clk_drive} <= i[3:0];
            repeat (2) @(posedge pclk);
            chk("pin_out", pin_out[5:2], i[3:0]);
        end
        chk("pin_oe", pin_oe, 6'h0f);
        wr(OFS_DIR, 0);
        ext[2] <= 1;
        repeat (6) @(posedge pclk);
        chk("pin_oe", pin_oe, 0);
        chk("serial0_ext_clk", serial0_ext_clk, 1);
        serial0_sync_mode <= 0;
        repeat (3) @(posedge pclk);
        chk("serial0_ext_clk", serial0_ext_clk, 0);
        wr(OFS_ALT_SEL, 0);
        wr(OFS_DIR, 32'h3c);
        wr(OFS_OUT_LATCH, 32'h28);
        repeat (2) @(posedge pclk);
        chk("pin_out", pin_out, 6'h0a);
        wr(OFS_DIR, 0);
        ext <= 6'h2d;
        repeat (4) @(posedge pclk);
        rd(OFS_PIN_IN, 32'hb4);
        ext <= 0;
        wr(OFS_IRQ_SENSE, 32'hf);
        wr(OFS_IRQ_MASK, 0);
        wr(OFS_ALT_SEL, 32'h3f);
        repeat (4) @(posedge pclk);
        ext <= 6'h3c;
        repeat (8) @(posedge pclk);
        rd(OFS_IRQ_STATUS, 32'h1f);
        chk("irq", irq, 0);
        rd(OFS_CAPTURE, 32'h1234);
        chk("count pulses", cnt_src, 1);
        chk("capture pulses", cap_hi, 1);
        chk("irq pulses", irq_hi, 4);
        wr(OFS_IRQ_MASK, 32'h1f);
        repeat (2) @(posedge pclk);
        chk("irq", irq, 1);
        wr(OFS_IRQ_STATUS, 32'h1f);
        repeat (2) @(posedge pclk);
        chk("irq", irq, 0);
        rd(OFS_IRQ_STATUS, 0);
        apb(0, 8'h40, 0);
        chk("pslverr", e, 1);
        chk("prdata", r, 0);
        // Level sense and falling-edge capture and count
        wr(OFS_IRQ_SENSE, 0);
        wr(OFS_ALT_SEL, 32'hc3f);
        tcount <= 16'h5678;
        ext <= 0;
        repeat (8) @(posedge pclk);
        chk("ext_irq_4", ext_irq_4, 1);
        chk("ext_irq_7", ext_irq_7, 1);
        rd(OFS_CAPTURE, 32'h5678);
        chk("count pulses", cnt_src, 2);
        chk("capture pulses", cap_hi, 2);
        // Pins still low: the level events win over the clear
        wr(OFS_IRQ_STATUS, 32'h1f);
        rd(OFS_IRQ_STATUS, 32'h0f);
        summarize;
    end
endmodule // tb_port_e_alt_function_mux
